// ==== design/liu_cfg_params.svh ====
`ifndef LIU_CFG_PARAMS_SVH
`define LIU_CFG_PARAMS_SVH

// ****************************************************************
// Register offsets and reset values
// ****************************************************************
`define OFS_CHAN0       8'h00
`define OFS_GLOBAL      8'h20
`define OFS_STATUS      8'h24
`define CHAN_RESET      18'h00000
`define GLB_RESET       2'h0
`define GLB_OVR_BIT     0
`define GLB_RATE_BIT    1

// ****************************************************************
// Clock selects and decode values
// ****************************************************************
`define CLKSEL_REF2048  3'h0
`define CLKSEL_REF1544  3'h1
`define IMP_OHM_00      8'h64
`define IMP_OHM_01      8'h6e
`define IMP_OHM_10      8'h4b
`define IMP_OHM_11      8'h78
`define RES_OHM_00      8'h00
`define RES_OHM_01      8'hf0
`define RES_OHM_10      8'hd2
`define RES_OHM_11      8'h96

// ****************************************************************
// Strap capture timing
// ****************************************************************
`define STRAP_TAKE      2'h2
`define STRAP_DONE      2'h3

`endif

// ==== design/liu_cfg_pkg.sv ====
package liu_cfg_pkg;

  typedef enum logic [2:0] {LB_NONE, LB_REMOTE, LB_ANALOG, LB_DIGITAL, LB_DUAL} loopback_t;

  typedef enum logic [1:0] {RATIO_UNITY, RATIO_UP, RATIO_DOWN, RATIO_NONE} ratio_t;

  typedef struct packed {
    loopback_t   loopback;
    logic        transmit_all_ones;
    logic        qrss_enable;
    logic        tx_termination_enable;
    logic        rx_termination_enable;
    logic [1:0]  jitter_attenuator_select;
    logic [4:0]  equalizer_shape_control;
    logic [1:0]  external_resistor_select;
    logic [1:0]  rx_impedance_select;
  } chan_cfg_t;

  typedef struct packed {
    chan_cfg_t   cfg;
    logic [7:0]  term_ohms;
    logic [7:0]  res_ohms;
  } eff_cfg_t;

endpackage

// ==== design/liu_mode_clock_termination_ctrl.sv ====
`timescale 1ns/100ps
`include "liu_cfg_params.svh"

// ****************************************************************
// Two-stage synchroniser
// ****************************************************************
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // sync2

// ****************************************************************
// Mode, clock and termination control
// ****************************************************************
module liu_mode_clock_termination_ctrl
  import liu_cfg_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic [7:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [31:0]     rdata_q,
  input  wire logic       hw_mode_pin,
  input  wire chan_cfg_t  hw_cfg_pin,
  input  wire logic       master_rate_select,
  input  wire logic       clock_select_bit2,
  input  wire logic       clock_select_bit1,
  input  wire logic       clock_select_bit0,
  input  wire logic       rx_termination_enable,
  input  wire logic       e1_reference_clock_in,
  input  wire logic       t1_reference_clock_in,
  input  wire logic [7:0] rx_line_positive,
  input  wire logic [7:0] rx_line_negative,
  output logic            hw_mode_q,
  output eff_cfg_t        eff_q [8],
  output logic            master_e1_q,
  output ratio_t          synth_ratio_q,
  output logic            clk_ok_q,
  output logic            ref_clk_q,
  output logic [7:0]      rx_recovered_clock_q,
  output logic [7:0]      rx_positive_rail_data_q,
  output logic [7:0]      rx_negative_rail_data_q
);
  localparam int SW = 42;

  logic [SW-1:0] pins_s;
  logic          hw_pin_s;
  chan_cfg_t     hw_cfg_s;
  logic          rate_s;
  logic [2:0]    clksel_s;
  logic          tpin_s;
  logic          e1_s;
  logic          t1_s;
  logic [7:0]    pos_s;
  logic [7:0]    neg_s;
  logic [1:0]    strap_cnt_q;
  chan_cfg_t     chan_q [8];
  logic [1:0]    glb_q;
  logic          wr_chan;
  logic          rd_chan;
  logic [2:0]    idx;
  logic [31:0]   status;
  logic [31:0]   rd_val;
  logic          ovr;
  logic          is2048;
  logic          is1544;
  logic          clk_ok;
  logic          rate_e1;
  ratio_t        ratio_d;

  function automatic logic [7:0] imp_ohms(input logic [1:0] s);
    return s == 2'h0 ? `IMP_OHM_00 : s == 2'h1 ? `IMP_OHM_01 :
           s == 2'h2 ? `IMP_OHM_10 : `IMP_OHM_11;
  endfunction

  function automatic logic [7:0] res_ohms(input logic [1:0] s);
    return s == 2'h0 ? `RES_OHM_00 : s == 2'h1 ? `RES_OHM_01 :
           s == 2'h2 ? `RES_OHM_10 : `RES_OHM_11;
  endfunction

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  // References are sampled, not used as clocks: 20 MHz is ample for 2 MHz
  sync2 #(
    .W (SW)
  ) u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      ({hw_mode_pin, hw_cfg_pin, master_rate_select, clock_select_bit2,
              clock_select_bit1, clock_select_bit0, rx_termination_enable,
              e1_reference_clock_in, t1_reference_clock_in, rx_line_positive,
              rx_line_negative}),
    .q      (pins_s)
  );

  assign {hw_pin_s, hw_cfg_s, rate_s, clksel_s, tpin_s, e1_s, t1_s, pos_s, neg_s} = pins_s;

  // Mode strap is taken once after the synchroniser has filled
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_cnt_q <= 2'h0;
      hw_mode_q   <= 1'b0;
    end
    else
    begin
      if (strap_cnt_q != `STRAP_DONE)
        strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == `STRAP_TAKE)
        hw_mode_q <= hw_pin_s;
    end
  end

  // ****************************************************************
  // Register port
  // ****************************************************************
  assign idx     = addr[4:2];
  assign wr_chan = wr && (addr < `OFS_GLOBAL) && (addr[1:0] == 2'h0);
  assign rd_chan = (addr < `OFS_GLOBAL) && (addr[1:0] == 2'h0);
  assign status  = {26'h0, clk_ok_q, synth_ratio_q, master_e1_q, tpin_s, hw_mode_q};
  assign rd_val  = rd_chan ? {14'h0, chan_q[idx]} :
                   addr == `OFS_GLOBAL ? {30'h0, glb_q} :
                   addr == `OFS_STATUS ? status : 32'h0;

  // Host writes are kept in hardware mode; channel writes have no effect there, the global override bit still does
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 8; i++)
        chan_q[i] <= chan_cfg_t'(`CHAN_RESET);
      glb_q   <= `GLB_RESET;
      rdata_q <= 32'h0;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
        if (wr_chan && idx == 3'(i))
          chan_q[i] <= chan_cfg_t'(wdata[17:0]);
      if (wr && addr == `OFS_GLOBAL)
        glb_q <= wdata[1:0];
      rdata_q <= rd ? rd_val : 32'h0;
    end
  end

  // ****************************************************************
  // Master clock selection
  // ****************************************************************
  assign is2048  = clksel_s == `CLKSEL_REF2048;
  assign is1544  = clksel_s == `CLKSEL_REF1544;
  assign clk_ok  = is2048 || is1544;
  // One rate for all channels: global bit in host mode, pin in hardware
  assign rate_e1 = hw_mode_q ? !rate_s : !glb_q[`GLB_RATE_BIT];
  assign ratio_d = !clk_ok ? RATIO_NONE :
                   rate_e1 ? (is2048 ? RATIO_UNITY : RATIO_UP) :
                   (is2048 ? RATIO_DOWN : RATIO_UNITY);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      master_e1_q   <= 1'b1;
      synth_ratio_q <= RATIO_UNITY;
      clk_ok_q      <= 1'b1;
      ref_clk_q     <= 1'b0;
    end
    else
    begin
      master_e1_q   <= rate_e1;
      synth_ratio_q <= ratio_d;
      clk_ok_q      <= clk_ok;
      // Each rate takes its own reference input
      ref_clk_q     <= clk_ok && (rate_e1 ? e1_s : t1_s);
    end
  end

  // ****************************************************************
  // Receivers
  // ****************************************************************
  // Both rails high is a line fault and yields no data bit
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_recovered_clock_q    <= 8'h00;
      rx_positive_rail_data_q <= 8'h00;
      rx_negative_rail_data_q <= 8'h00;
    end
    else
    begin
      rx_recovered_clock_q    <= pos_s ^ neg_s;
      rx_positive_rail_data_q <= pos_s & ~neg_s;
      rx_negative_rail_data_q <= neg_s & ~pos_s;
    end
  end

  // ****************************************************************
  // Effective per-channel configuration
  // ****************************************************************
  assign ovr = glb_q[`GLB_OVR_BIT];

  for (genvar i = 0; i < 8; i++)
  begin : g_ch
    chan_cfg_t src;
    chan_cfg_t fix;
    eff_cfg_t  nxt;
    logic      lb_bad;

    // Hardware mode feeds every channel from the same strap set
    assign src    = hw_mode_q ? hw_cfg_s : chan_q[i];
    assign lb_bad = (src.loopback > LB_DUAL) || (hw_mode_q && src.loopback == LB_DUAL);

    always_comb
    begin
      fix             = src;
      fix.qrss_enable = src.qrss_enable && !hw_mode_q;
      fix.loopback    = lb_bad ? LB_NONE : src.loopback;
      fix.rx_termination_enable = ovr ? tpin_s : src.rx_termination_enable;
    end

    assign nxt = '{cfg: fix,
                   term_ohms: imp_ohms(fix.rx_impedance_select),
                   res_ohms: res_ohms(fix.external_resistor_select)};

    always_ff @(posedge mclk or negedge arst_n)
    begin
      if (!arst_n)
        eff_q[i] <= '0;
      else
        eff_q[i] <= nxt;
    end

    a_term_override: assert property (@(posedge mclk) disable iff (!arst_n)
      $past(ovr) |-> eff_q[i].cfg.rx_termination_enable == $past(tpin_s))
      else $error("termination pin override not applied");

    a_term_register: assert property (@(posedge mclk) disable iff (!arst_n)
      !$past(ovr) && !$past(hw_mode_q) |->
      eff_q[i].cfg.rx_termination_enable == $past(chan_q[i].rx_termination_enable))
      else $error("termination bit not followed");

    a_hw_global_cfg: assert property (@(posedge mclk) disable iff (!arst_n)
      $past(hw_mode_q) |->
      eff_q[i].cfg.rx_impedance_select == $past(hw_cfg_s.rx_impedance_select) &&
      eff_q[i].cfg.equalizer_shape_control == $past(hw_cfg_s.equalizer_shape_control) &&
      eff_q[i].cfg.jitter_attenuator_select == $past(hw_cfg_s.jitter_attenuator_select))
      else $error("hardware mode setting not global");

    a_hw_no_qrss: assert property (@(posedge mclk) disable iff (!arst_n)
      $past(hw_mode_q) |-> !eff_q[i].cfg.qrss_enable &&
      eff_q[i].cfg.transmit_all_ones == $past(hw_cfg_s.transmit_all_ones))
      else $error("qrss active in hardware mode");

    a_hw_no_dual: assert property (@(posedge mclk) disable iff (!arst_n)
      $past(hw_mode_q) |-> eff_q[i].cfg.loopback != LB_DUAL)
      else $error("dual loopback in hardware mode");

    a_host_dual_ok: assert property (@(posedge mclk) disable iff (!arst_n)
      !$past(hw_mode_q) && $past(chan_q[i].loopback) == LB_DUAL |->
      eff_q[i].cfg.loopback == LB_DUAL)
      else $error("dual loopback lost in host mode");

    a_imp_decode: assert property (@(posedge mclk) disable iff (!arst_n)
      eff_q[i].cfg.rx_impedance_select == 2'h2 |-> eff_q[i].term_ohms == 8'h4b)
      else $error("impedance decode wrong");

    a_res_decode: assert property (@(posedge mclk) disable iff (!arst_n)
      eff_q[i].cfg.external_resistor_select == 2'h1 |-> eff_q[i].res_ohms == 8'hf0)
      else $error("resistor decode wrong");
  end

  // ****************************************************************
  // Clock and register checks
  // ****************************************************************
  sequence s_sel000;
    clksel_s == 3'h0;
  endsequence

  sequence s_sel001;
    clksel_s == 3'h1;
  endsequence

  a_clk_sel000: assert property (@(posedge mclk) disable iff (!arst_n)
    s_sel000 |=> synth_ratio_q == (master_e1_q ? RATIO_UNITY : RATIO_DOWN))
    else $error("select 000 master clock wrong");

  a_clk_sel001: assert property (@(posedge mclk) disable iff (!arst_n)
    s_sel001 |=> synth_ratio_q == (master_e1_q ? RATIO_UP : RATIO_UNITY))
    else $error("select 001 master clock wrong");

  a_host_rate: assert property (@(posedge mclk) disable iff (!arst_n)
    !hw_mode_q && !$past(hw_mode_q) |-> master_e1_q == !$past(glb_q[1]))
    else $error("host line rate not from global register");

  sequence s_glb_read;
    rd && addr == 8'h20;
  endsequence

  a_glb_readback: assert property (@(posedge mclk) disable iff (!arst_n)
    s_glb_read |=> rdata_q == {30'h0, $past(glb_q)} ##1 rdata_q == 32'h0 || $past(rd))
    else $error("global register read wrong");

endmodule // liu_mode_clock_termination_ctrl

// ==== tb/board_refs.sv ====
`timescale 1ns/100ps
// ********
// Board reference clocks
// ********
module board_refs (
  input  wire logic one_src,
  input  wire logic src_1544,
  output logic      e1_ref,
  output logic      t1_ref
);
  logic c2048 = 1'b0;
  logic c1544 = 1'b0;
  // Free-running oscillators, unrelated in phase to mclk
  always #244 c2048 = ~c2048;
  always #324 c1544 = ~c1544;
  // With one_src set, a single source feeds both inputs so the rates do not split
  assign e1_ref = (one_src && src_1544) ? c1544 : c2048;
  assign t1_ref = (one_src && !src_1544) ? c2048 : c1544;
endmodule // board_refs

// ==== tb/liu_mode_clock_termination_ctrl_bench.sv ====
`timescale 1ns/100ps
`include "liu_cfg_params.svh"
module liu_mode_clock_termination_ctrl_bench
  import liu_cfg_pkg::*;
();
  // ********
  // Signals and clock
  // ********
  logic       mclk   = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] addr   = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic       wr     = 1'b0;
  logic       rd     = 1'b0;
  logic       hw_pin = 1'b0;
  chan_cfg_t  hw_cfg = '0;
  logic       rate   = 1'b0;
  logic [2:0] csel   = 3'h0;
  logic       term   = 1'b0;
  logic       one    = 1'b1;
  logic       s1544  = 1'b0;
  logic [7:0] pos    = 8'h00;
  logic [7:0] neg    = 8'h00;
  logic [31:0] rdata_q;
  logic       e1_ref, t1_ref, hw_q, e1_q, ok_q, ref_q;
  logic [7:0] rclk, rx_positive_rail_data, rx_negative_rail_data;
  ratio_t     ratio;
  eff_cfg_t   eff [8];
  chan_cfg_t  ec [8];
  logic [7:0] imp_t [4] = '{`IMP_OHM_00, `IMP_OHM_01, `IMP_OHM_10, `IMP_OHM_11};
  logic [7:0] res_t [4] = '{`RES_OHM_00, `RES_OHM_01, `RES_OHM_10, `RES_OHM_11};
  int         num_errors = 0;
  int         cmp_count  = 0;
  always #25 mclk = ~mclk;

  board_refs board_u (.one_src(one), .src_1544(s1544), .e1_ref(e1_ref), .t1_ref(t1_ref));

  liu_mode_clock_termination_ctrl dut_u (
    .mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .hw_mode_pin(hw_pin), .hw_cfg_pin(hw_cfg),
    .master_rate_select(rate), .clock_select_bit2(csel[2]),
    .clock_select_bit1(csel[1]), .clock_select_bit0(csel[0]),
    .rx_termination_enable(term), .e1_reference_clock_in(e1_ref),
    .t1_reference_clock_in(t1_ref), .rx_line_positive(pos), .rx_line_negative(neg),
    .hw_mode_q(hw_q), .eff_q(eff), .master_e1_q(e1_q), .synth_ratio_q(ratio),
    .clk_ok_q(ok_q), .ref_clk_q(ref_q), .rx_recovered_clock_q(rclk),
    .rx_positive_rail_data_q(rx_positive_rail_data), .rx_negative_rail_data_q(rx_negative_rail_data)
  );

  // ********
  // Helpers
  // ********
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(rdata_q, exp);
  endtask

  // Strap must be steady across release, so it moves only inside reset
  task do_reset(input logic hw);
    @(posedge mclk);
    hw_pin <= hw;
    arst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask

  task settle;
    repeat (5) @(posedge mclk);
    #1;
  endtask

  // The synchroniser and output stage delay the reference by two edges
  task ref_chk(input logic use_e1);
    logic [2:0] h;
    h = 3'h0;
    for (int c = 0; c < 12; c++)
    begin
      @(posedge mclk);
      h = {h[1:0], use_e1 ? e1_ref : t1_ref};
      #1;
      if (c >= 2)
        chk(ref_q, h[2]);
    end
  endtask

  // ********
  // Scenarios
  // ********
  task t_reset;
    do_reset(1'b0);
    #1 chk(hw_q, 1'b0);
    chk(e1_q, 1'b1);
    for (int n = 0; n < 8; n++)
      chk(eff[n].cfg.rx_termination_enable, 1'b0);
    rd_chk(`OFS_STATUS, 32'h24);
    wr_reg(8'h30, 32'hffff_ffff);
    rd_chk(8'h30, 32'h0);
    $display("test reset done");
  endtask

  task t_clock;
    logic s;
    for (int i = 0; i < 6; i++)
    begin
      s = (i < 4) ? i[1] : i[0];
      @(posedge mclk);
      one <= (i < 4);
      s1544 <= s;
      csel <= {2'b00, s};
      wr_reg(`OFS_GLOBAL, {30'h0, i[0], 1'b0});
      settle;
      chk(e1_q, !i[0]);
      chk(ratio, (s == i[0]) ? RATIO_UNITY : (s ? RATIO_UP : RATIO_DOWN));
      chk(ok_q, 1'b1);
      ref_chk(!i[0]);
    end
    @(posedge mclk);
    csel <= 3'h2;
    settle;
    chk(ok_q, 1'b0);
    chk(ratio, RATIO_NONE);
    chk(ref_q, 1'b0);
    @(posedge mclk);
    csel <= 3'h0;
    one <= 1'b1;
    s1544 <= 1'b0;
    $display("test clock done");
  endtask

  task t_host_chan;
    for (int n = 0; n < 8; n++)
    begin
      ec[n] = '0;
      ec[n].rx_impedance_select = n[1:0];
      ec[n].external_resistor_select = n[2:1];
      ec[n].equalizer_shape_control = 5'(n + 3);
      ec[n].jitter_attenuator_select = n[1:0];
      ec[n].tx_termination_enable = n[0];
      ec[n].rx_termination_enable = n[2];
      ec[n].qrss_enable = n[0];
      ec[n].loopback = loopback_t'(n % 5);
      wr_reg(8'(4 * n), 32'(ec[n]));
    end
    settle;
    for (int n = 0; n < 8; n++)
    begin
      chk(32'(eff[n].cfg), 32'(ec[n]));
      chk(eff[n].term_ohms, imp_t[n % 4]);
      chk(eff[n].res_ohms, res_t[n / 2]);
    end
    rd_chk(8'h10, 32'(ec[4]));
    $display("test host channels done");
  endtask

  task t_override;
    @(posedge mclk);
    term <= 1'b1;
    settle;
    for (int n = 0; n < 8; n++)
      chk(eff[n].cfg.rx_termination_enable, n[2]);
    wr_reg(`OFS_GLOBAL, 32'h1);
    settle;
    for (int n = 0; n < 8; n++)
      chk(eff[n].cfg.rx_termination_enable, 1'b1);
    @(posedge mclk);
    term <= 1'b0;
    settle;
    for (int n = 0; n < 8; n++)
      chk(eff[n].cfg.rx_termination_enable, 1'b0);
    wr_reg(`OFS_GLOBAL, 32'h0);
    $display("test override done");
  endtask

  task t_rx;
    @(posedge mclk);
    pos <= 8'ha5;
    neg <= 8'h3c;
    settle;
    // Rails high together carry no data bit on either output
    chk(rx_positive_rail_data, 8'h81);
    chk(rx_negative_rail_data, 8'h18);
    chk(rclk, 8'h99);
    $display("test receive done");
  endtask

  task t_hw_mode;
    chan_cfg_t e;
    @(posedge mclk);
    hw_cfg <= '{LB_DUAL, 1'b1, 1'b1, 1'b1, 1'b1, 2'h2, 5'h15, 2'h3, 2'h2};
    rate <= 1'b1;
    do_reset(1'b1);
    settle;
    e = '{LB_NONE, 1'b1, 1'b0, 1'b1, 1'b1, 2'h2, 5'h15, 2'h3, 2'h2};
    chk(hw_q, 1'b1);
    chk(e1_q, 1'b0);
    for (int n = 0; n < 8; n++)
    begin
      chk(32'(eff[n].cfg), 32'(e));
      chk(eff[n].term_ohms, `IMP_OHM_10);
      chk(eff[n].res_ohms, `RES_OHM_11);
    end
    // Host writes are kept but must not leak into hardware mode
    wr_reg(`OFS_CHAN0, 32'h0);
    // Dual and undefined loopback codes fall back to none here
    for (int l = 1; l < 6; l++)
    begin
      @(posedge mclk);
      hw_cfg.loopback <= loopback_t'(l);
      settle;
      chk(eff[0].cfg.loopback, (l < 4) ? l : 0);
      chk(eff[0].cfg.equalizer_shape_control, 5'h15);
    end
    $display("test hardware mode done");
  endtask

  // ********
  // Main sequence
  // ********
  task results;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    t_reset;
    t_clock;
    t_host_chan;
    t_override;
    t_rx;
    t_hw_mode;
    results;
  end

  // About 260 cycles are needed; allow nearly forty times that
  initial
  begin
    #500000;
    num_errors++;
    results;
  end
endmodule // liu_mode_clock_termination_ctrl_bench
